//--- emulation_memory_map_guard.sv
// memory map, wait-state and access-restriction logic for an emulator
`timescale 1ns/1ps
//
// Overview of operation
// - each block routed to one of four targets
// - 32K emulation RAM, zero to fifteen waits
// - 256K expansion RAM, programmable wait states
// - host memory per 1K block, not on PC
// - host memory accesses stretched by 25 waits
// - prototype memory runs unstretched, RAM waits per block
// - mapping changeable one block at a time
// - program write to read-only block flags error
// - command writes may enter read-only blocks
// - command writes are read back and compared
// - no-verify blocks skip the read-back
// - reset marks every block guarded
// - guarded blocks refuse program and command access
module emulation_memory_map_guard
  import emu_map_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // emulated processor cycles
  input  wire logic              cpu_req_i,
  input  wire logic              cpu_we_i,
  input  wire logic [ADDR_W-1:0] cpu_addr_i,
  input  wire logic [DATA_W-1:0] cpu_wdata_i,
  output logic                   cpu_ready_o,
  output logic      [DATA_W-1:0] cpu_rdata_o,
  output logic                   cpu_refused_o,
  output logic                   cpu_ro_err_o,
  // debugger command path
  input  wire logic              cmd_req_i,
  input  wire logic              cmd_we_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_wdata_i,
  output logic                   cmd_done_o,
  output logic      [DATA_W-1:0] cmd_rdata_o,
  output logic                   cmd_refused_o,
  output logic                   verify_fail_o,
  output logic                   busy_o,
  // map programming
  input  wire logic              host_is_pc_i,
  input  wire logic              map_we_i,
  input  wire logic [BLK_IW-1:0] map_block_i,
  input  wire logic [1:0]        map_target_i,
  input  wire logic [3:0]        map_wait_i,
  input  wire logic              map_ro_i,
  input  wire logic              map_nv_i,
  input  wire logic              map_guard_i,
  output logic                   map_reject_o,
  // guard violation record
  input  wire logic              viol_clr_i,
  output logic                   viol_flag_o,
  output logic      [ADDR_W-1:0] viol_addr_o,
  output logic                   viol_src_o,
  // host bus and prototype memory, four-phase handshake
  output logic                   ext_req_o,
  output logic                   ext_host_o,
  output logic                   ext_we_o,
  output logic      [ADDR_W-1:0] ext_addr_o,
  output logic      [DATA_W-1:0] ext_wdata_o,
  input  wire logic              ext_ack_i,
  input  wire logic [DATA_W-1:0] ext_rdata_i
);

  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_MEM, S_MEMRD, S_EXT, S_REL} state_t;

  // ==========================================================================
  // map table
  logic [1:0]      tgt_mem  [0:NBLK-1];
  logic [3:0]      wait_mem [0:NBLK-1];
  logic            ro_mem   [0:NBLK-1];
  logic            nv_mem   [0:NBLK-1];
  logic [NBLK-1:0] guard_q;

  // host target is not offered behind a PC host
  wire map_ok = map_we_i && !(host_is_pc_i && map_target_i == TGT_HOST);

  // one block per write, others untouched
  always_ff @(posedge sys_clk_i)
  begin
    if (map_ok)
    begin
      tgt_mem[map_block_i]  <= map_target_i;
      wait_mem[map_block_i] <= map_wait_i;
      ro_mem[map_block_i]   <= map_ro_i;
      nv_mem[map_block_i]   <= map_nv_i;
    end
  end

  // guard bits kept apart so reset can set them all
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      guard_q      <= {NBLK{RST_GUARD}};
      map_reject_o <= 1'b0;
    end
    else
    begin
      if (map_ok)
      begin
        guard_q[map_block_i] <= map_guard_i;
      end
      map_reject_o <= map_we_i && !map_ok;
    end
  end

  // ==========================================================================
  // request arbitration and block lookup
  logic              busy_q;
  wire               take_cpu  = !busy_q && cpu_req_i;
  wire               take_cmd  = !busy_q && !cpu_req_i && cmd_req_i;
  wire               take      = take_cpu || take_cmd;
  wire [ADDR_W-1:0]  req_addr  = take_cpu ? cpu_addr_i : cmd_addr_i;
  wire               req_we    = take_cpu ? cpu_we_i : cmd_we_i;
  wire [DATA_W-1:0]  req_wdata = take_cpu ? cpu_wdata_i : cmd_wdata_i;
  wire [BLK_IW-1:0]  blk       = req_addr[ADDR_W-1:BLK_W];
  wire [1:0]         blk_tgt   = tgt_mem[blk];
  wire               hit_guard = guard_q[blk];
  wire               take_grd  = take && hit_guard;
  wire               take_ro   = take_cpu && cpu_we_i && ro_mem[blk] && !hit_guard;
  wire               take_go   = take && !hit_guard && !take_ro;

  // host memory always stretched, prototype never, RAM per block
  wire [WAIT_W-1:0]  blk_waits = (blk_tgt == TGT_HOST)  ? HOST_WAITS :
                                 (blk_tgt == TGT_PROTO) ? NO_WAITS :
                                 {1'b0, wait_mem[blk]};

  // ==========================================================================
  // access engine state
  state_t            st_q;
  logic              src_cmd_q;
  logic              we_q;
  logic              ver_q;
  logic              nv_q;
  logic [1:0]        tgt_q;
  logic [WAIT_W-1:0] waits_q;
  logic [WAIT_W-1:0] wcnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] ext_rd_q;
  logic              ack_meta_q;
  logic              ack_s_q;
  logic [DATA_W-1:0] emul_rd;
  logic [DATA_W-1:0] exp_rd;

  // prototype acknowledge comes from a pin
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_meta_q <= 1'b0;
      ack_s_q    <= 1'b0;
    end
    else
    begin
      ack_meta_q <= ext_ack_i;
      ack_s_q    <= ack_meta_q;
    end
  end

  // ==========================================================================
  // on-board and expansion RAM
  wire is_ext   = (tgt_q == TGT_HOST) || (tgt_q == TGT_PROTO);
  wire ram_cyc  = (st_q == S_MEM);
  wire emul_en  = ram_cyc && (tgt_q == TGT_EMUL);
  wire exp_en   = ram_cyc && (tgt_q == TGT_EXP);
  wire ram_wr   = ram_cyc && we_q;              // only reached when writing is allowed
  wire [DATA_W-1:0] ram_rd = (tgt_q == TGT_EXP) ? exp_rd : emul_rd;

  emu_ram #(.AW(EMUL_AW), .DW(DATA_W)) u_emul_ram
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .en_i      (emul_en),
    .we_i      (we_q),
    .addr_i    (addr_q[EMUL_AW-1:0]),
    .wdata_i   (wdata_q),
    .rdata_o   (emul_rd)
  );

  emu_ram #(.AW(EXP_AW), .DW(DATA_W)) u_exp_ram
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .en_i      (exp_en),
    .we_i      (we_q),
    .addr_i    (addr_q[EXP_AW-1:0]),
    .wdata_i   (wdata_q),
    .rdata_o   (exp_rd)
  );

  // ==========================================================================
  // completion and read-back decisions
  wire              fin      = (st_q == S_MEMRD) || (st_q == S_REL && !ack_s_q);
  wire [DATA_W-1:0] rd_now   = (st_q == S_MEMRD) ? ram_rd : ext_rd_q;
  wire              need_ver = src_cmd_q && we_q && !nv_q && !ver_q;
  wire              ver_bad  = ver_q && (rd_now != wdata_q);

  // sequencer; answer pulses default low every cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= S_IDLE;
      busy_q <= 1'b0;
      src_cmd_q <= 1'b0;
      we_q <= 1'b0;
      ver_q <= 1'b0;
      nv_q <= 1'b0;
      tgt_q <= RST_TGT;
      waits_q <= NO_WAITS;
      wcnt_q <= NO_WAITS;
      addr_q <= '0;
      wdata_q <= '0;
      ext_rd_q <= '0;
      cpu_ready_o <= 1'b0;
      cpu_rdata_o <= '0;
      cpu_refused_o <= 1'b0;
      cpu_ro_err_o <= 1'b0;
      cmd_done_o <= 1'b0;
      cmd_rdata_o <= '0;
      cmd_refused_o <= 1'b0;
      verify_fail_o <= 1'b0;
      ext_req_o <= 1'b0;
      ext_host_o <= 1'b0;
      ext_we_o <= 1'b0;
      ext_addr_o <= '0;
      ext_wdata_o <= '0;
    end
    else
    begin
      cpu_ready_o <= 1'b0;
      cpu_refused_o <= 1'b0;
      cpu_ro_err_o <= 1'b0;
      cmd_done_o <= 1'b0;
      cmd_refused_o <= 1'b0;
      verify_fail_o <= 1'b0;
      unique case (st_q)
        S_IDLE:
        begin
          if (take_grd)
          begin
            cpu_refused_o <= take_cpu;
            cmd_refused_o <= take_cmd;
          end
          else if (take_ro)
          begin
            cpu_ready_o  <= 1'b1;                           // no memory cycle
            cpu_ro_err_o <= 1'b1;
          end
          else if (take_go)
          begin
            busy_q    <= 1'b1;
            st_q      <= S_WAIT;
            src_cmd_q <= take_cmd;                          // no read-only check
            we_q      <= req_we;
            ver_q     <= 1'b0;
            nv_q      <= nv_mem[blk];
            tgt_q     <= blk_tgt;
            waits_q   <= blk_waits;
            wcnt_q    <= blk_waits;
            addr_q    <= req_addr;
            wdata_q   <= req_wdata;
          end
        end
        S_WAIT:
        begin
          if (wcnt_q != NO_WAITS)
          begin
            wcnt_q <= wcnt_q - 5'h01;
          end
          else if (is_ext)
          begin
            st_q        <= S_EXT;
            ext_req_o   <= 1'b1;
            ext_host_o  <= (tgt_q == TGT_HOST);
            ext_we_o    <= we_q;
            ext_addr_o  <= addr_q;
            ext_wdata_o <= wdata_q;
          end
          else
          begin
            st_q <= S_MEM;
          end
        end
        S_MEM:
        begin
          st_q <= S_MEMRD;
        end
        S_EXT:
        begin
          if (ack_s_q)
          begin
            ext_rd_q  <= ext_rdata_i;
            ext_req_o <= 1'b0;
            st_q      <= S_REL;
          end
        end
        S_MEMRD, S_REL:
        begin
          if (fin && need_ver)
          begin
            we_q   <= 1'b0;                                 // read the byte back
            ver_q  <= 1'b1;
            wcnt_q <= waits_q;
            st_q   <= S_WAIT;
          end
          else if (fin)
          begin
            busy_q        <= 1'b0;
            st_q          <= S_IDLE;
            ver_q         <= 1'b0;
            cpu_ready_o   <= !src_cmd_q;
            cmd_done_o    <= src_cmd_q;
            cpu_rdata_o   <= src_cmd_q ? cpu_rdata_o : rd_now;
            cmd_rdata_o   <= src_cmd_q ? rd_now : cmd_rdata_o;
            verify_fail_o <= src_cmd_q && ver_bad;
          end
        end
      endcase
    end
  end

  // busy mirrors the engine flop
  assign busy_o = busy_q;

  // ==========================================================================
  // guard violation record; a new refusal wins over a clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      viol_flag_o <= 1'b0;
      viol_addr_o <= '0;
      viol_src_o  <= 1'b0;
    end
    else if (take_grd)
    begin
      viol_flag_o <= 1'b1;
      viol_addr_o <= req_addr;
      viol_src_o  <= take_cmd;
    end
    else if (viol_clr_i)
    begin
      viol_flag_o <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_guard_refuse: assert property (take_grd |=> (cpu_refused_o || cmd_refused_o) && !busy_o)
    else $error("guarded access not refused");
  a_viol_record: assert property (take_grd |=> viol_flag_o && viol_addr_o == $past(req_addr))
    else $error("violation not recorded");
  a_ro_error: assert property (take_ro |=> cpu_ro_err_o && cpu_ready_o && !busy_o)
    else $error("read-only write not reported");
  a_ro_untouched: assert property (ram_wr |-> src_cmd_q || !ro_mem[addr_q[ADDR_W-1:BLK_W]] || map_ok)
    else $error("program write reached read-only block");
  a_cmd_ro_write: assert property (take_cmd && cmd_we_i && ro_mem[blk] && !hit_guard && !is_ext
    && blk_tgt != TGT_HOST && blk_tgt != TGT_PROTO |=> busy_o)
    else $error("command write to read-only block blocked");
  a_host_stretch: assert property (take_go && blk_tgt == TGT_HOST |=> wcnt_q == HOST_WAITS)
    else $error("host access not stretched");
  a_emul_fast: assert property (take_go && blk_tgt == TGT_EMUL && wait_mem[blk] == 4'h0 && !req_we
    |-> ##4 (cpu_ready_o || cmd_done_o))
    else $error("zero-wait emulation access delayed");
  a_pc_no_host: assert property (map_we_i && host_is_pc_i && map_target_i == TGT_HOST |=> map_reject_o)
    else $error("host target offered on PC host");
  a_verify_skip: assert property (fin && src_cmd_q && we_q && nv_q |=> st_q == S_IDLE && cmd_done_o)
    else $error("no-verify block was read back");
  a_verify_run: assert property (fin && need_ver |=> st_q == S_WAIT && !we_q && !cmd_done_o)
    else $error("command write not verified");
  a_map_block: assert property (map_ok |=> tgt_mem[$past(map_block_i)] == $past(map_target_i))
    else $error("map entry not updated");

endmodule

//--- emu_map_pkg.sv
// shared constants for the emulation memory map guard
package emu_map_pkg;

  // ==========================================================================
  // address space and block geometry
  localparam int ADDR_W  = 20;              // emulated processor address width
  localparam int DATA_W  = 8;               // byte-wide accesses
  localparam int BLK_W   = 10;              // 1K bytes per map block
  localparam int NBLK    = 1 << (ADDR_W - BLK_W);
  localparam int BLK_IW  = ADDR_W - BLK_W;

  // ==========================================================================
  // memory resources
  localparam int EMUL_AW = 15;              // 32K bytes on-board emulation RAM
  localparam int EXP_AW  = 18;              // 256K bytes expansion (two 128K boards)

  // ==========================================================================
  // map target codes
  localparam logic [1:0] TGT_EMUL  = 2'h0;
  localparam logic [1:0] TGT_EXP   = 2'h1;
  localparam logic [1:0] TGT_HOST  = 2'h2;
  localparam logic [1:0] TGT_PROTO = 2'h3;

  // ==========================================================================
  // wait-state counts, in clock cycles
  localparam int         WAIT_W     = 5;
  localparam logic [4:0] HOST_WAITS = 5'h19;  // 25 inserted wait states
  localparam logic [4:0] NO_WAITS   = 5'h00;

  // ==========================================================================
  // reset values
  localparam logic [1:0] RST_TGT   = TGT_EMUL;
  localparam logic       RST_GUARD = 1'b1;    // every block starts guarded

endpackage

//--- emu_ram.sv
// single-port byte RAM with registered read data
`timescale 1ns/1ps
module emu_ram
#(
  parameter int AW = 15,
  parameter int DW = 8
)
(
  input  wire logic          sys_clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          en_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  // ==========================================================================
  // storage
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // array has no reset; contents are undefined until loaded
  always_ff @(posedge sys_clk_i)
  begin
    if (en_i && we_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  // read data valid the cycle after the enable
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= '0;
    end
    else if (en_i)
    begin
      rdata_o <= mem_q[addr_i];
    end
  end

endmodule

//--- ext_mem_model.sv
// behavioural host bus and prototype memory on the four-phase handshake
`timescale 1ns/1ps
module ext_mem_model
(
  input  wire logic        sys_clk_i,
  input  wire logic        ext_req_i,
  input  wire logic        ext_host_i,
  input  wire logic        ext_we_i,
  input  wire logic [19:0] ext_addr_i,
  input  wire logic [7:0]  ext_wdata_i,
  input  wire logic        slow_i,
  input  wire logic        bad_i,
  output logic             ext_ack_o,
  output logic      [7:0]  ext_rdata_o,
  output int               n_rd_o
);
  logic [7:0] mem_q [0:2047];
  int         dly_q;

  // ==========================================================================
  // responder
  // quiet data line is inverted, so a late capture by the device shows up
  initial
  begin
    ext_ack_o   = 1'b0;
    ext_rdata_o = 8'h5A;
    n_rd_o      = 0;
    dly_q       = 0;
  end

  // ack on the second or seventh edge that sees the request; bad_i corrupts read data on purpose
  always @(posedge sys_clk_i)
  begin
    if (ext_req_i && !ext_ack_o)
    begin
      dly_q <= dly_q + 1;
      if (dly_q >= (slow_i ? 6 : 1))
      begin
        dly_q     <= 0;
        ext_ack_o <= 1'b1;
        if (ext_we_i)
          mem_q[{ext_host_i, ext_addr_i[9:0]}] <= ext_wdata_i;
        else
        begin
          ext_rdata_o <= mem_q[{ext_host_i, ext_addr_i[9:0]}] ^ {8{bad_i}};
          n_rd_o      <= n_rd_o + 1;
        end
      end
    end
    else if (!ext_req_i && ext_ack_o)
    begin
      ext_ack_o   <= 1'b0;
      ext_rdata_o <= ~ext_rdata_o;
    end
  end
endmodule

//--- test_emulation_memory_map_guard.sv
// self-checking testbench for the emulation memory map guard
`timescale 1ns/1ps
module test_emulation_memory_map_guard;
  import emu_map_pkg::*;
  logic              sys_clk, reset_n, cpu_req, cpu_we, cpu_ready, cpu_refused, cpu_ro_err;
  logic              cmd_req, cmd_we, cmd_done, cmd_refused, verify_fail, busy;
  logic              host_is_pc, map_we, map_ro, map_nv, map_guard, map_reject;
  logic              viol_clr, viol_flag, viol_src, ext_req, ext_host, ext_we, ext_ack;
  logic              slow, bad, rej;
  logic [ADDR_W-1:0] cpu_addr, cmd_addr, viol_addr, ext_addr;
  logic [7:0]        cpu_wdata, cpu_rdata, cmd_wdata, cmd_rdata, ext_wdata, ext_rdata, rd;
  logic [BLK_IW-1:0] map_block;
  logic [1:0]        map_target;
  logic [3:0]        map_wait;
  logic [2:0]        fl;
  int                n, n_rd, nr0, n_mismatch, n_checks;
  logic [1:0]        tg [4];
  int                bk [4];
  int                wt [4];

  emulation_memory_map_guard emulation_memory_map_guard_i (.sys_clk_i(sys_clk),
    .reset_n_i(reset_n), .cpu_req_i(cpu_req), .cpu_we_i(cpu_we), .cpu_addr_i(cpu_addr),
    .cpu_wdata_i(cpu_wdata), .cpu_ready_o(cpu_ready), .cpu_rdata_o(cpu_rdata),
    .cpu_refused_o(cpu_refused), .cpu_ro_err_o(cpu_ro_err), .cmd_req_i(cmd_req),
    .cmd_we_i(cmd_we), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_done_o(cmd_done),
    .cmd_rdata_o(cmd_rdata), .cmd_refused_o(cmd_refused), .verify_fail_o(verify_fail),
    .busy_o(busy), .host_is_pc_i(host_is_pc), .map_we_i(map_we), .map_block_i(map_block),
    .map_target_i(map_target), .map_wait_i(map_wait), .map_ro_i(map_ro), .map_nv_i(map_nv),
    .map_guard_i(map_guard), .map_reject_o(map_reject), .viol_clr_i(viol_clr),
    .viol_flag_o(viol_flag), .viol_addr_o(viol_addr), .viol_src_o(viol_src),
    .ext_req_o(ext_req), .ext_host_o(ext_host), .ext_we_o(ext_we), .ext_addr_o(ext_addr),
    .ext_wdata_o(ext_wdata), .ext_ack_i(ext_ack), .ext_rdata_i(ext_rdata));

  ext_mem_model ext_mem_model_i (.sys_clk_i(sys_clk), .ext_req_i(ext_req),
    .ext_host_i(ext_host), .ext_we_i(ext_we), .ext_addr_i(ext_addr), .ext_wdata_i(ext_wdata),
    .slow_i(slow), .bad_i(bad), .ext_ack_o(ext_ack), .ext_rdata_o(ext_rdata), .n_rd_o(n_rd));

  // ==========================================================================
  // clock, 20 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // helpers
  // distinct low bits per block keep the far-side memory slots apart
  function automatic logic [19:0] ad(input int b);
    return {b[9:0], 2'b00, b[7:0]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one map entry; reject pulse is looked at in the cycle it stands
  task automatic map(input int b, input logic [1:0] t, input int w, input logic ro, nv, g);
    map_block  = b[9:0];
    map_target = t;
    map_wait   = w[3:0];
    map_ro     = ro;
    map_nv     = nv;
    map_guard  = g;
    map_we     = 1'b1;
    @(negedge sys_clk);
    rej    = map_reject;
    map_we = 1'b0;
    @(negedge sys_clk);
  endtask

  // one access; n counts edges after the take edge, fl = {refused, done, error}
  // a refusal pulse stands only until the next edge, so look right after the take
  task automatic acc(input logic src, we, input logic [19:0] a, input logic [7:0] d);
    cpu_we    = we;
    cpu_addr  = a;
    cpu_wdata = d;
    cmd_we    = we;
    cmd_addr  = a;
    cmd_wdata = d;
    cpu_req   = !src;
    cmd_req   = src;
    @(negedge sys_clk);
    cpu_req = 1'b0;
    cmd_req = 1'b0;
    n       = 0;
    fl      = src ? {cmd_refused, cmd_done, verify_fail} : {cpu_refused, cpu_ready, cpu_ro_err};
    while (n < 300 && fl === 3'h0)
    begin
      @(negedge sys_clk);
      n++;
      fl = src ? {cmd_refused, cmd_done, verify_fail} : {cpu_refused, cpu_ready, cpu_ro_err};
    end
    rd = src ? cmd_rdata : cpu_rdata;
    if (fl === 3'h0)
    begin
      n_mismatch++;
      close_out();
    end
  endtask

  // ==========================================================================
  // main sequence, inputs change at the falling edge
  initial
  begin
    {cpu_req, cpu_we, cmd_req, cmd_we, host_is_pc, map_we, map_ro, map_nv} = '0;
    {map_guard, viol_clr, slow, bad, reset_n} = '0;
    {cpu_addr, cmd_addr, cpu_wdata, cmd_wdata, map_block, map_target, map_wait} = '0;
    n_mismatch = 0;
    n_checks   = 0;
    tg = '{TGT_EMUL, TGT_EMUL, TGT_EXP, TGT_EXP};
    bk = '{0, 1, 2, 255};
    wt = '{0, 15, 0, 3};
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    chk(viol_flag, 0);
    acc(0, 0, ad(0), 8'h00); chk(fl, 3'b100); chk(n, 0);
    chk(busy, 0);
    chk(viol_flag, 1); chk(viol_addr, ad(0)); chk(viol_src, 0);
    acc(1, 1, ad(1), 8'h11); chk(fl, 3'b100); chk(viol_src, 1);
    chk(viol_addr, ad(1));
    viol_clr = 1'b1;
    @(negedge sys_clk);
    viol_clr = 1'b0;
    @(negedge sys_clk);
    chk(viol_flag, 0);
    $display("test guard finished");
    // emulation and expansion RAM, waits from the table
    for (int i = 0; i < 4; i++)
    begin
      map(bk[i], tg[i], wt[i], 0, 0, 0); chk(rej, 0);
      acc(1, 1, ad(bk[i]), 8'h20 + i); chk(fl, 3'b010); chk(rd, 8'h20 + i);
      acc(0, 0, ad(bk[i]), 8'h00); chk(rd, 8'h20 + i); chk(n, 3 + wt[i]);
    end
    $display("test ram finished");
    // read-only block 0
    map(0, TGT_EMUL, 0, 1, 0, 0);
    acc(0, 1, ad(0), 8'hEE); chk(fl, 3'b011); chk(n, 0);
    acc(0, 0, ad(0), 8'h00); chk(rd, 8'h20);
    acc(1, 1, ad(0), 8'h77); chk(fl, 3'b010);
    acc(0, 0, ad(0), 8'h00); chk(rd, 8'h77);
    $display("test read-only finished");
    // host memory: refused on a pc host, slow otherwise
    host_is_pc = 1'b1;
    map(4, TGT_HOST, 0, 0, 0, 0); chk(rej, 1);
    acc(0, 0, ad(4), 8'h00); chk(fl, 3'b100);
    host_is_pc = 1'b0;
    map(4, TGT_HOST, 0, 0, 0, 0); chk(rej, 0);
    acc(0, 1, ad(4), 8'h3C); chk(fl, 3'b010); chk(n > 28, 1);
    slow = 1'b1;
    acc(0, 0, ad(4), 8'h00); chk(rd, 8'h3C); chk(n > 28, 1);
    slow = 1'b0;
    $display("test host finished");
    // prototype memory, with and without read-back
    map(5, TGT_PROTO, 0, 0, 1, 0);
    nr0 = n_rd;
    acc(1, 1, ad(5), 8'h5C); chk(fl, 3'b010); chk(n_rd, nr0);
    map(6, TGT_PROTO, 0, 0, 0, 0);
    acc(1, 1, ad(6), 8'h66); chk(fl, 3'b010); chk(n_rd, nr0 + 1);
    bad = 1'b1;
    acc(1, 1, ad(6), 8'hA5); chk(fl, 3'b011); chk(rd, 8'h5A);
    bad = 1'b0;
    acc(0, 0, ad(5), 8'h00); chk(rd, 8'h5C); chk(n < 28, 1);
    $display("test prototype finished");
    // move block 1 to prototype and back, block 0 untouched
    map(1, TGT_PROTO, 0, 0, 0, 0);
    acc(1, 1, ad(1), 8'h42); chk(fl, 3'b010);
    acc(0, 0, ad(0), 8'h00); chk(rd, 8'h77);
    map(1, TGT_EMUL, 15, 0, 0, 0);
    acc(0, 0, ad(1), 8'h00); chk(rd, 8'h21);
    map(1, TGT_PROTO, 0, 0, 0, 0);
    acc(0, 0, ad(1), 8'h00); chk(rd, 8'h42);
    $display("test remap finished");
    close_out();
  end
endmodule
